// ===== core/scd_cmd_decoder.v
`timescale 1ns/1ps
`include "scd_consts.vh"

// Summary of operation
// - tx disable command stops transmitter after buffer (async) or frame (sync) ends.
// - tx disable command drops the transmit ready flag at once.
// - tx crc init command presets crc at next shift-register load.
// - crc exclusion command skips only next character loaded into shift register.
// - end-of-message command tags next character entering transmit buffer as last.
// - word write tags upper byte in cpu mode 0, lower byte otherwise.
// - tagged last character is followed by crc, or fcs plus flag.
// - abort command sends all-ones abort at once and flushes the buffer.
// - mp-bit-on command marks only next character entering transmit buffer.
// - tx buffer clear command flushes buffer, no register touched.
// - rx reset halts receiver, flushes receive buffer, clears receive status.
// - command register is write-only, reads zero, upper two bits ignored.
// - tx reset disables transmitter at mark, clears buffer, status, break.
// - tx enable moves a disabled transmitter to idle.
module scd_cmd_decoder (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [31:0] s_axi_araddr,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        irq,
    input  wire        tx_shift_load,
    input  wire        tx_buf_load,
    input  wire        tx_buf_word,
    input  wire        tx_buf_room,
    input  wire        tx_buf_empty,
    input  wire        tx_busy,
    input  wire        tx_frame_end,
    output wire        tx_enabled,
    output wire        tx_line_mark,
    output wire        tx_ready_flag,
    output wire        tx_crc_init,
    output wire        tx_crc_skip,
    output wire        tx_eom_tag,
    output wire        tx_eom_hi_byte,
    output wire        tx_trailer_flag,
    output wire        tx_mp_tag,
    output wire        tx_abort,
    output wire        tx_buf_flush,
    output wire        tx_status_clear,
    output wire        line_break_clear,
    output wire        rx_enabled,
    output wire        rx_buf_flush,
    output wire        rx_status_clear,
    output wire        crc_preset_select
);

    // --------------------
    // transmitter and receiver states
    // --------------------
    localparam [2:0] TX_DIS  = 3'h1;
    localparam [2:0] TX_IDLE = 3'h2;
    localparam [2:0] TX_STOP = 3'h4;
    localparam [1:0] RX_DIS  = 2'h1;
    localparam [1:0] RX_ON   = 2'h2;

    reg [2:0]               tx_state_reg;
    reg [2:0]               tx_state_next;
    reg [1:0]               rx_state_reg;
    reg [1:0]               rx_state_next;
    reg [`SCD_MODE_W-1:0]   mode_reg;
    reg [`SCD_IRQ_W-1:0]    istat_reg;
    reg [`SCD_IRQ_W-1:0]    imask_reg;
    reg                     irq_reg, ready_reg;
    reg                     crci_pend_reg, crcx_pend_reg, eom_pend_reg, mp_pend_reg;
    reg                     crc_init_reg, crc_skip_reg, eom_tag_reg, eom_hi_reg;
    reg                     trailer_reg, mp_tag_reg, abort_reg, txflush_reg;
    reg                     txstat_clr_reg, brk_clr_reg, rxflush_reg, rxstat_clr_reg;

    // --------------------
    // axi4-lite write channel
    // --------------------
    reg                     aw_full_reg, aw_open_reg;
    reg                     w_full_reg, w_open_reg;
    reg [`SCD_ADDR_W-1:0]   aw_addr_reg;
    reg [31:0]              w_data_reg;
    reg [3:0]               w_strb_reg;
    reg                     bvalid_reg;
    reg [1:0]               bresp_reg;
    reg                     arready_reg;
    reg                     rvalid_reg;
    reg [31:0]              rdata_reg;
    reg [1:0]               rresp_reg;

    wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire wr_lo = wr_go & w_strb_reg[0];
    wire wr_cmd = wr_lo & (aw_addr_reg == `SCD_OFS_CMD);
    wire [`SCD_CMD_W-1:0] cmd = w_data_reg[`SCD_CMD_W-1:0];
    wire wr_map = (aw_addr_reg == `SCD_OFS_CMD) | (aw_addr_reg == `SCD_OFS_MODE) |
                  (aw_addr_reg == `SCD_OFS_ISTAT) | (aw_addr_reg == `SCD_OFS_IMASK);

    // one command at a time; bresp holds back the next write
    always @(posedge ref_clk) begin
        if (!rstn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_open_reg <= 1'b1;
            w_open_reg  <= 1'b1;
            aw_addr_reg <= {`SCD_ADDR_W{1'b0}};
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SCD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & ~aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_open_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr[`SCD_ADDR_W-1:0];
            end
            if (s_axi_wvalid & ~w_full_reg) begin
                w_full_reg <= 1'b1;
                w_open_reg <= 1'b0;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_map ? `SCD_RESP_OKAY : `SCD_RESP_SLVERR;
            end
            if (bvalid_reg & s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                aw_open_reg <= 1'b1;
                w_open_reg  <= 1'b1;
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
            end
        end
    end

    // --------------------
    // axi4-lite read channel
    // --------------------
    wire [`SCD_ADDR_W-1:0] ra = s_axi_araddr[`SCD_ADDR_W-1:0];
    wire [31:0] stat_word = {20'h0_0000, rx_state_reg, tx_state_reg, mp_pend_reg,
                             eom_pend_reg, crcx_pend_reg, crci_pend_reg,
                             tx_buf_empty, tx_busy, ready_reg};

    always @(posedge ref_clk) begin
        if (!rstn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `SCD_RESP_OKAY;
        end else begin
            arready_reg <= 1'b0;
            if (s_axi_arvalid & ~arready_reg & ~rvalid_reg) begin
                arready_reg <= 1'b1;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= `SCD_RESP_OKAY;
                case (ra)
                    `SCD_OFS_CMD:   rdata_reg <= 32'h0000_0000;
                    `SCD_OFS_MODE:  rdata_reg <= {27'h000_0000, mode_reg};
                    `SCD_OFS_STAT:  rdata_reg <= stat_word;
                    `SCD_OFS_ISTAT: rdata_reg <= {28'h000_0000, istat_reg};
                    `SCD_OFS_IMASK: rdata_reg <= {28'h000_0000, imask_reg};
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= `SCD_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_reg & s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // --------------------
    // transmitter and receiver state
    // --------------------
    wire fmt_async = (mode_reg[`SCD_FMT_HI:`SCD_FMT_LO] == `SCD_FMT_ASYNC);
    wire fmt_bit   = (mode_reg[`SCD_FMT_HI:`SCD_FMT_LO] == `SCD_FMT_BIT);
    wire stop_done = fmt_async ? (tx_buf_empty & ~tx_busy) : tx_frame_end;

    always @* begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            TX_DIS: begin
                if (wr_cmd & (cmd == `SCD_CMD_TXEN))
                    tx_state_next = TX_IDLE;
            end
            TX_IDLE: begin
                if (wr_cmd & (cmd == `SCD_CMD_TXDIS))
                    tx_state_next = TX_STOP;
            end
            TX_STOP: begin
                if (stop_done)
                    tx_state_next = TX_DIS;
            end
            default: tx_state_next = TX_DIS;
        endcase
        if (wr_cmd & (cmd == `SCD_CMD_TXRST))
            tx_state_next = TX_DIS;
    end

    always @* begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            RX_DIS:  if (wr_cmd & (cmd == `SCD_CMD_RXEN)) rx_state_next = RX_ON;
            RX_ON:   rx_state_next = RX_ON;
            default: rx_state_next = RX_DIS;
        endcase
        if (wr_cmd & (cmd == `SCD_CMD_RXRST))
            rx_state_next = RX_DIS;
    end

    // --------------------
    // command decode and one-shot tags
    // --------------------
    // tags are armed by a command and spent by the next load; a load in
    // the command's own cycle belongs to the older character
    wire is_rst = wr_cmd & (cmd == `SCD_CMD_TXRST);
    wire is_clr = wr_cmd & ((cmd == `SCD_CMD_TXCLR) | (cmd == `SCD_CMD_ABORT));

    always @(posedge ref_clk) begin
        if (!rstn) begin
            tx_state_reg   <= TX_DIS;
            rx_state_reg   <= RX_DIS;
            ready_reg      <= 1'b0;
            {crci_pend_reg, crcx_pend_reg, eom_pend_reg, mp_pend_reg} <= 4'h0;
            {crc_init_reg, crc_skip_reg, eom_tag_reg, eom_hi_reg, trailer_reg} <= 5'h00;
            {mp_tag_reg, abort_reg, txflush_reg, txstat_clr_reg} <= 4'h0;
            {brk_clr_reg, rxflush_reg, rxstat_clr_reg} <= 3'h0;
        end else begin
            tx_state_reg   <= tx_state_next;
            rx_state_reg   <= rx_state_next;
            crc_init_reg   <= tx_shift_load & crci_pend_reg;
            crc_skip_reg   <= tx_shift_load & crcx_pend_reg;
            eom_tag_reg    <= tx_buf_load & eom_pend_reg;
            mp_tag_reg     <= tx_buf_load & mp_pend_reg;
            {abort_reg, txflush_reg, txstat_clr_reg} <= 3'h0;
            {brk_clr_reg, rxflush_reg, rxstat_clr_reg} <= 3'h0;
            ready_reg <= (tx_state_next == TX_IDLE) & tx_buf_room;
            if (tx_shift_load) crci_pend_reg <= 1'b0;
            if (wr_cmd & (cmd == `SCD_CMD_TXCRCI)) crci_pend_reg <= 1'b1;
            if (tx_shift_load) crcx_pend_reg <= 1'b0;
            if (wr_cmd & (cmd == `SCD_CMD_TXCRCX)) crcx_pend_reg <= 1'b1;
            if (tx_buf_load) eom_pend_reg <= 1'b0;
            if (wr_cmd & (cmd == `SCD_CMD_EOM)) eom_pend_reg <= 1'b1;
            eom_hi_reg <= tx_buf_word &
                          (mode_reg[`SCD_CPU_HI:`SCD_CPU_LO] == `SCD_CPU_MODE0);
            // fcs plus flag in bit sync
            trailer_reg <= fmt_bit;
            if (tx_buf_load) mp_pend_reg <= 1'b0;
            if (wr_cmd & (cmd == `SCD_CMD_MPON)) mp_pend_reg <= 1'b1;
            if (wr_cmd & (cmd == `SCD_CMD_ABORT)) abort_reg <= 1'b1;
            if (is_clr | is_rst) txflush_reg <= 1'b1;
            if (is_rst) begin
                txstat_clr_reg <= 1'b1;
                brk_clr_reg    <= 1'b1;
                crci_pend_reg  <= 1'b0;
                crcx_pend_reg  <= 1'b0;
                eom_pend_reg   <= 1'b0;
                mp_pend_reg    <= 1'b0;
            end
            if (wr_cmd & (cmd == `SCD_CMD_RXRST)) begin
                rxflush_reg    <= 1'b1;
                rxstat_clr_reg <= 1'b1;
            end
        end
    end

    // --------------------
    // mode, interrupt status and mask
    // --------------------
    wire [`SCD_IRQ_W-1:0] ev;
    // transmit codes form one contiguous run
    wire known = ((cmd >= `SCD_CMD_TXRST) & (cmd <= `SCD_CMD_TXCLR)) |
                 (cmd == `SCD_CMD_RXRST) | (cmd == `SCD_CMD_RXEN);
    assign ev[`SCD_IRQ_TXOFF]  = (tx_state_reg == TX_STOP) & (tx_state_next == TX_DIS);
    assign ev[`SCD_IRQ_ABORT]  = wr_cmd & (cmd == `SCD_CMD_ABORT);
    assign ev[`SCD_IRQ_RXRST]  = wr_cmd & (cmd == `SCD_CMD_RXRST);
    assign ev[`SCD_IRQ_BADCMD] = wr_cmd & ~known;

    wire [`SCD_IRQ_W-1:0] w1c = (wr_lo & (aw_addr_reg == `SCD_OFS_ISTAT)) ?
                                w_data_reg[`SCD_IRQ_W-1:0] : {`SCD_IRQ_W{1'b0}};
    wire [`SCD_IRQ_W-1:0] istat_next = (istat_reg & ~w1c) | ev;

    // new events win over a clear in the same cycle
    always @(posedge ref_clk) begin
        if (!rstn) begin
            mode_reg  <= `SCD_MODE_RST;
            istat_reg <= {`SCD_IRQ_W{1'b0}};
            imask_reg <= {`SCD_IRQ_W{1'b0}};
            irq_reg   <= 1'b0;
        end else begin
            istat_reg <= istat_next;
            irq_reg   <= |(istat_next & imask_reg);
            if (wr_lo & (aw_addr_reg == `SCD_OFS_MODE))
                mode_reg <= w_data_reg[`SCD_MODE_W-1:0];
            if (wr_lo & (aw_addr_reg == `SCD_OFS_IMASK))
                imask_reg <= w_data_reg[`SCD_IRQ_W-1:0];
        end
    end

    // --------------------
    // outputs
    // --------------------
    assign s_axi_awready     = aw_open_reg;
    assign s_axi_wready      = w_open_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = arready_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;
    assign irq               = irq_reg;
    assign tx_enabled        = ~tx_state_reg[0];
    assign tx_line_mark      = tx_state_reg[0];
    assign tx_ready_flag     = ready_reg;
    assign tx_crc_init       = crc_init_reg;
    assign tx_crc_skip       = crc_skip_reg;
    assign tx_eom_tag        = eom_tag_reg;
    assign tx_eom_hi_byte    = eom_hi_reg;
    assign tx_trailer_flag   = trailer_reg;
    assign tx_mp_tag         = mp_tag_reg;
    assign tx_abort          = abort_reg;
    assign tx_buf_flush      = txflush_reg;
    assign tx_status_clear   = txstat_clr_reg;
    assign line_break_clear  = brk_clr_reg;
    assign rx_enabled        = rx_state_reg[1];
    assign rx_buf_flush      = rxflush_reg;
    assign rx_status_clear   = rxstat_clr_reg;
    assign crc_preset_select = mode_reg[`SCD_CRCP_BIT];

endmodule // scd_cmd_decoder

// ===== core/scd_consts.vh
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

// --------------------
// register byte offsets
// --------------------
`define SCD_ADDR_W      5
`define SCD_OFS_CMD     5'h00
`define SCD_OFS_MODE    5'h04
`define SCD_OFS_STAT    5'h08
`define SCD_OFS_ISTAT   5'h0c
`define SCD_OFS_IMASK   5'h10

// --------------------
// command codes
// --------------------
`define SCD_CMD_W       6
`define SCD_CMD_TXRST   6'h01
`define SCD_CMD_TXEN    6'h02
`define SCD_CMD_TXDIS   6'h03
`define SCD_CMD_TXCRCI  6'h04
`define SCD_CMD_TXCRCX  6'h05
`define SCD_CMD_EOM     6'h06
`define SCD_CMD_ABORT   6'h07
`define SCD_CMD_MPON    6'h08
`define SCD_CMD_TXCLR   6'h09
`define SCD_CMD_RXRST   6'h11
`define SCD_CMD_RXEN    6'h12

// --------------------
// mode register fields
// --------------------
`define SCD_MODE_W      5
`define SCD_MODE_RST    5'h00
`define SCD_FMT_HI      1
`define SCD_FMT_LO      0
`define SCD_CRCP_BIT    2
`define SCD_CPU_HI      4
`define SCD_CPU_LO      3
`define SCD_FMT_ASYNC   2'h0
`define SCD_FMT_BYTE    2'h1
`define SCD_FMT_BIT     2'h2
`define SCD_CPU_MODE0   2'h0

// --------------------
// interrupt bits, bus responses
// --------------------
`define SCD_IRQ_W       4
`define SCD_IRQ_TXOFF   0
`define SCD_IRQ_ABORT   1
`define SCD_IRQ_RXRST   2
`define SCD_IRQ_BADCMD  3
`define SCD_RESP_OKAY   2'h0
`define SCD_RESP_SLVERR 2'h2

`endif

// ===== verif/scd_tx_model.sv
`timescale 1ns/1ps
// --------------------
// transmit datapath stand-in: two-entry buffer, shifter
// --------------------
module scd_tx_model #(parameter int SHIFT_LEN = 7) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic push,
    input  wire logic push_word,
    input  wire logic tx_enabled,
    input  wire logic tx_buf_flush,
    output logic      tx_shift_load,
    output logic      tx_buf_load,
    output logic      tx_buf_word,
    output wire       tx_buf_room,
    output wire       tx_buf_empty,
    output wire       tx_busy,
    output logic      tx_frame_end
);
    logic [1:0] fill_reg = 2'h0;
    logic [2:0] bits_reg = 3'h0;
    wire        start    = tx_enabled && bits_reg == 3'h0 && fill_reg != 2'h0;
    assign tx_busy      = bits_reg != 3'h0;
    assign tx_buf_empty = fill_reg == 2'h0;
    assign tx_buf_room  = fill_reg < 2'h2;
    initial {tx_shift_load, tx_buf_load, tx_buf_word, tx_frame_end} = 4'h0;
    // a slow shifter keeps a character on the line across a whole bus write
    always @(posedge ref_clk) begin
        if (!rstn) begin
            {fill_reg, bits_reg, tx_shift_load, tx_buf_load, tx_frame_end} <= 8'h0;
        end else begin
            tx_buf_load   <= push && tx_buf_room;
            tx_buf_word   <= push_word;
            tx_shift_load <= start;
            tx_frame_end  <= bits_reg == 3'h1 && fill_reg == 2'h0;
            bits_reg      <= start ? 3'(SHIFT_LEN) : bits_reg - {2'h0, tx_busy};
            fill_reg      <= tx_buf_flush ? 2'h0 : fill_reg + {1'b0, tx_buf_load} - {1'b0, start};
        end
    end
endmodule // scd_tx_model

// ===== verif/scd_cmd_checker.sv
`timescale 1ns/1ps
`include "scd_consts.vh"
module scd_cmd_checker (
    input wire        ref_clk,
    input wire        rstn,
    input wire        s_axi_awvalid,
    input wire [31:0] s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire        tx_buf_load,
    input wire        tx_buf_word,
    input wire        tx_enabled,
    input wire        tx_line_mark,
    input wire        tx_ready_flag,
    input wire        tx_eom_tag,
    input wire        tx_eom_hi_byte,
    input wire        tx_abort,
    input wire        tx_buf_flush,
    input wire        tx_status_clear,
    input wire        line_break_clear,
    input wire        rx_enabled,
    input wire        rx_buf_flush,
    input wire        rx_status_clear
);
    reg  [31:0] waddr_reg;
    reg  [31:0] wdata_reg;
    reg  [31:0] raddr_reg;
    reg  [3:0]  wstrb_reg;
    reg  [4:0]  mode_reg;
    wire        cmd_wr = waddr_reg[4:0] == `SCD_OFS_CMD && wstrb_reg[0];
    wire [5:0]  cmd    = cmd_wr ? wdata_reg[5:0] : 6'h3f;
    // master holds payload until taken
    always @(posedge ref_clk) begin
        if (s_axi_awvalid) waddr_reg <= s_axi_awaddr;
        if (s_axi_wvalid) wdata_reg <= s_axi_wdata;
        if (s_axi_wvalid) wstrb_reg <= s_axi_wstrb;
        if (s_axi_arvalid) raddr_reg <= s_axi_araddr;
        if (!rstn) mode_reg <= `SCD_MODE_RST;
        else if ($rose(s_axi_bvalid) && waddr_reg[4:0] == `SCD_OFS_MODE && wstrb_reg[0])
            mode_reg <= wdata_reg[4:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence cmd_seen(logic [5:0] c);
        $rose(s_axi_bvalid) && cmd == c;
    endsequence
    cmd_read_zero_a: assert property (
        $rose(s_axi_rvalid) && raddr_reg[4:0] == `SCD_OFS_CMD |-> s_axi_rdata == 32'h0)
        else $error("command read nonzero");
    disable_ready_a: assert property (
        cmd_seen(`SCD_CMD_TXDIS) |-> !tx_ready_flag)
        else $error("ready flag kept after tx disable");
    tx_reset_a: assert property (
        cmd_seen(`SCD_CMD_TXRST) |-> tx_line_mark && !tx_enabled && tx_buf_flush
        && tx_status_clear && line_break_clear)
        else $error("tx reset effects missing");
    abort_flush_a: assert property (
        cmd_seen(`SCD_CMD_ABORT) |-> tx_abort && tx_buf_flush ##1 !tx_abort)
        else $error("abort pulse wrong");
    buf_clear_a: assert property (
        cmd_seen(`SCD_CMD_TXCLR) |-> tx_buf_flush && !tx_abort && !tx_status_clear
        && !rx_buf_flush)
        else $error("buffer clear too wide");
    rx_reset_a: assert property (
        cmd_seen(`SCD_CMD_RXRST) |-> !rx_enabled && rx_buf_flush && rx_status_clear)
        else $error("rx reset effects missing");
    tx_enable_a: assert property (
        cmd_seen(`SCD_CMD_TXEN) ##0 $past(tx_line_mark) |-> tx_enabled && !tx_line_mark)
        else $error("tx enable failed");
    eom_byte_a: assert property (
        tx_eom_tag |-> $past(tx_buf_load)
        && tx_eom_hi_byte == ($past(tx_buf_word) && mode_reg[4:3] == `SCD_CPU_MODE0))
        else $error("eom tag wrong");
    unassigned_a: assert property (
        cmd_seen(6'h0a) |-> !(tx_abort || tx_buf_flush || tx_status_clear || rx_buf_flush
        || rx_status_clear) && tx_enabled == $past(tx_enabled))
        else $error("unassigned code acted");
endmodule // scd_cmd_checker

bind scd_cmd_decoder scd_cmd_checker chk (.*);

// ===== verif/serial_channel_command_decoder_bench.sv
`timescale 1ns/1ps
`include "scd_consts.vh"
`define CHK(nm, e, s) begin \
    n_checks++; \
    if ((s) !== (e)) begin \
        n_mismatch++; \
        $display("unexpected %s expected %h seen %h", nm, e, s); \
    end \
end
module serial_channel_command_decoder_bench;
    logic ref_clk = 1'b0, rstn = 1'b0, push = 1'b0, push_word = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic tx_shift_load, tx_buf_load, tx_buf_word, tx_buf_room, tx_buf_empty, tx_busy;
    logic tx_frame_end, tx_enabled, tx_line_mark, tx_ready_flag, tx_crc_init, tx_crc_skip;
    logic tx_eom_tag, tx_eom_hi_byte, tx_trailer_flag, tx_mp_tag, tx_abort, tx_buf_flush;
    logic tx_status_clear, line_break_clear, rx_enabled, rx_buf_flush, rx_status_clear;
    logic crc_preset_select, eom_hi;
    logic [5:0]  pl;
    logic [31:0] rv;
    int n_checks = 0, n_mismatch = 0, n_init = 0, n_skip = 0, n_eom = 0, n_mp = 0;
    scd_cmd_decoder uut (.*);
    scd_tx_model model (.*);
    always #12.5 ref_clk = ~ref_clk;
    // count one-cycle tags mid-cycle
    always @(negedge ref_clk) begin
        n_init += tx_crc_init;
        n_skip += tx_crc_skip;
        n_mp   += tx_mp_tag;
        if (tx_eom_tag === 1'b1) n_eom++;
        if (tx_eom_tag === 1'b1) eom_hi = tx_eom_hi_byte;
    end
    // --------------------
    // bus and stream tasks
    // --------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic fail_out();
        n_mismatch++;
        summarize();
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [1:0] hs;
        int i;
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        {s_axi_awaddr, s_axi_wdata} <= {27'h0, a, d};
        for (i = 0; i < 40; i++) begin
            @(negedge ref_clk);
            if (s_axi_bvalid === 1'b1) break;
            hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready};
            @(posedge ref_clk);
            if (hs[1]) s_axi_awvalid <= 1'b0;
            if (hs[0]) s_axi_wvalid <= 1'b0;
        end
        if (i == 40) fail_out();
        rsp = s_axi_bresp;
        pl = {tx_abort, tx_buf_flush, tx_status_clear, line_break_clear, rx_buf_flush,
              rx_status_clear};
        @(posedge ref_clk);
        s_axi_bready <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        int i;
        @(posedge ref_clk);
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, 27'h0, a};
        for (i = 0; i < 40; i++) begin
            @(negedge ref_clk);
            if (s_axi_rvalid === 1'b1) break;
        end
        if (i == 40) fail_out();
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge ref_clk);
        {s_axi_arvalid, s_axi_rready} <= 2'b00;
        @(negedge ref_clk);
    endtask
    task automatic put(input logic w);
        @(posedge ref_clk);
        {push, push_word} <= {1'b1, w};
        @(posedge ref_clk);
        push <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 200 && !(tx_buf_empty === 1'b1 && tx_busy === 1'b0); i++)
            @(negedge ref_clk);
        if (i == 200) fail_out();
        repeat (3) @(negedge ref_clk);
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_reset_enable();
        `CHK("tx_line_mark", 1'b1, tx_line_mark)
        rd(`SCD_OFS_CMD, rv);
        `CHK("cmd read", 32'h0, rv)
        rd(5'h1c, rv);
        `CHK("unmapped resp", `SCD_RESP_SLVERR, rsp)
        wr(`SCD_OFS_STAT, 32'h0);
        `CHK("write resp", `SCD_RESP_SLVERR, rsp)
        wr(`SCD_OFS_CMD, 32'hc2);
        `CHK("write resp", `SCD_RESP_OKAY, rsp)
        `CHK("tx_enabled", 1'b1, tx_enabled)
        `CHK("tx_line_mark", 1'b0, tx_line_mark)
        repeat (2) @(negedge ref_clk);
        `CHK("tx_ready_flag", 1'b1, tx_ready_flag)
    endtask
    task automatic t_tags();
        wr(`SCD_OFS_MODE, 32'h05);
        `CHK("crc_preset_select", 1'b1, crc_preset_select)
        `CHK("tx_trailer_flag", 1'b0, tx_trailer_flag)
        wr(`SCD_OFS_CMD, `SCD_CMD_TXCRCI);
        wr(`SCD_OFS_CMD, `SCD_CMD_EOM);
        put(1'b1);
        // exclusion written while the first, eom-tagged character shifts out
        wr(`SCD_OFS_CMD, `SCD_CMD_TXCRCX);
        put(1'b0);
        put(1'b0);
        drain();
        `CHK("crc init count", 1, n_init)
        `CHK("crc skip count", 1, n_skip)
        `CHK("eom count", 1, n_eom)
        `CHK("eom upper byte", 1'b1, eom_hi)
        wr(`SCD_OFS_MODE, 32'h12);
        `CHK("tx_trailer_flag", 1'b1, tx_trailer_flag)
        wr(`SCD_OFS_CMD, `SCD_CMD_EOM);
        put(1'b1);
        wr(`SCD_OFS_CMD, `SCD_CMD_MPON);
        put(1'b0);
        put(1'b0);
        drain();
        `CHK("eom count", 2, n_eom)
        `CHK("eom upper byte", 1'b0, eom_hi)
        `CHK("mp count", 1, n_mp)
    endtask
    task automatic t_events();
        wr(`SCD_OFS_IMASK, 32'hf);
        wr(`SCD_OFS_CMD, `SCD_CMD_TXCLR);
        `CHK("pulses", 6'b010000, pl)
        wr(`SCD_OFS_CMD, `SCD_CMD_ABORT);
        `CHK("pulses", 6'b110000, pl)
        `CHK("irq", 1'b1, irq)
        wr(`SCD_OFS_ISTAT, 32'h2);
        `CHK("irq", 1'b0, irq)
        wr(`SCD_OFS_CMD, `SCD_CMD_RXEN);
        `CHK("rx_enabled", 1'b1, rx_enabled)
        wr(`SCD_OFS_CMD, `SCD_CMD_RXRST);
        `CHK("pulses", 6'b000011, pl)
        `CHK("rx_enabled", 1'b0, rx_enabled)
        wr(`SCD_OFS_ISTAT, 32'h4);
        wr(`SCD_OFS_CMD, 32'h0a);
        `CHK("pulses", 6'b000000, pl)
        rd(`SCD_OFS_ISTAT, rv);
        `CHK("istat", 32'h8, rv)
        wr(`SCD_OFS_IMASK, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        wr(`SCD_OFS_ISTAT, 32'h8);
    endtask
    task automatic t_disable();
        int i;
        wr(`SCD_OFS_MODE, 32'h0);
        put(1'b0);
        put(1'b0);
        wr(`SCD_OFS_CMD, `SCD_CMD_TXDIS);
        `CHK("tx_ready_flag", 1'b0, tx_ready_flag)
        `CHK("tx_enabled", 1'b1, tx_enabled)
        for (i = 0; i < 100 && tx_enabled !== 1'b0; i++) @(negedge ref_clk);
        if (i == 100) fail_out();
        `CHK("tx_buf_empty", 1'b1, tx_buf_empty)
        `CHK("tx_busy", 1'b0, tx_busy)
        rd(`SCD_OFS_ISTAT, rv);
        `CHK("istat", 32'h1, rv)
    endtask
    task automatic t_reset_tx();
        wr(`SCD_OFS_CMD, `SCD_CMD_TXEN);
        put(1'b0);
        wr(`SCD_OFS_CMD, `SCD_CMD_TXRST);
        `CHK("pulses", 6'b011100, pl)
        `CHK("tx_line_mark", 1'b1, tx_line_mark)
        `CHK("tx_enabled", 1'b0, tx_enabled)
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        t_reset_enable();
        t_tags();
        t_events();
        t_disable();
        t_reset_tx();
        summarize();
    end
endmodule // serial_channel_command_decoder_bench
